// ### rtl/tlbc_pkg.sv
// tlb control package: register indices, field layouts, reset values, segment codes
// assumes the pipeline addresses these registers by their coprocessor register number
// Summary of operation
// - on a miss, va[31:13] is written into the miss page pair field
// - page size mask bits 24:13 drop matching address bits from tag compare
// - mask register is source on entry write and destination on entry read
// - random pointer never goes below the locked entry boundary, or below 15 when the boundary exceeds 15
// - locked entry boundary clears to zero on reset
// - any write to the boundary forces the random pointer to its upper bound
// - the indexed pointer ignores the boundary and reaches every entry
// - fault address captures va of address error, tlb and coherency exceptions
// - fault address holds while exception level bit is one
// - bus errors never load the fault address
// - tlb refill, invalid or modified loads entry high page pair; address_space_id keeps its value
// - entry high is page pair 31:13, zeros 12:8, address_space_id 7:0
// - any exception enters privileged mode until exception return
// - user mode only when user bit 1 and exception and error levels 0
// - user mode gives one translated 2 Gbyte space, cached per entry
// - privileged, msb clear selects the mapped user segment with address_space_id
// - privileged 100 segment is unmapped cached, pa is va minus 0x8000_0000
// - privileged 101 segment is unmapped uncached, pa is va minus 0xa000_0000
// - top byte c0 to fe is mapped; top 16 MBytes mapped only if config bit 3
// - sixteen fully associative entries, each an even/odd page pair
// - random pointer resets to 15, decrements per valid instruction
package tlbc_pkg;

  // ---------------------------------------------------------------
  // register numbers
  // ---------------------------------------------------------------
  localparam logic [4:0] TLBC_REG_PTR   = 5'h04;
  localparam logic [4:0] TLBC_REG_MASK  = 5'h05;
  localparam logic [4:0] TLBC_REG_BOUND = 5'h06;
  localparam logic [4:0] TLBC_REG_FVA   = 5'h08;
  localparam logic [4:0] TLBC_REG_EHI   = 5'h0a;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          TLBC_ENTRIES     = 16;
  localparam int          TLBC_PAGE_PAIR_NUMBER_LO     = 13;
  localparam int          TLBC_MASK_LO     = 13;
  localparam int          TLBC_MASK_W      = 12;
  localparam int          TLBC_PTR_PAGE_PAIR_NUMBER_LO = 4;
  localparam int          TLBC_PTR_BASE_LO = 23;
  localparam int          TLBC_BOUND_W     = 6;
  localparam logic [5:0]  TLBC_BOUND_RST   = 6'h00;
  localparam logic [3:0]  TLBC_RAND_TOP    = 4'hf;
  localparam int          TLBC_CFG_MAPTOP_BIT = 3;
  localparam logic [31:0] TLBC_SEG0_BASE   = 32'h8000_0000;
  localparam logic [31:0] TLBC_SEG1_BASE   = 32'ha000_0000;
  localparam logic [7:0]  TLBC_ONCHIP_TOP  = 8'hff;

  // ---------------------------------------------------------------
  // segment kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TLBC_SEG_USER    = 3'b000,
    TLBC_SEG_CACHED  = 3'b001,
    TLBC_SEG_UNCACHE = 3'b010,
    TLBC_SEG_KMAPPED = 3'b011,
    TLBC_SEG_ONCHIP  = 3'b100
  } tlbc_seg_t;

endpackage

// ### rtl/tlbc_top.sv
// tlb control registers, replacement pointer, tag compare and segment decode
// assumes the pipeline presents register accesses, tlb instructions and exception pulses on mclk_in
`timescale 1ns/10ps
module tlbc_top
  import tlbc_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // register access by coprocessor register number
  input  wire logic        reg_wr_in,
  input  wire logic [4:0]  reg_num_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // status bits from the pipeline
  input  wire logic        user_mode_bit_in,
  input  wire logic        exception_level_bit_in,
  input  wire logic        error_level_bit_in,
  input  wire logic        cfg_map_top_in,
  input  wire logic [2:0]  segment_coherency_field_in,
  // exception entry
  input  wire logic        exc_take_in,
  input  wire logic        exc_addr_err_in,
  input  wire logic        exc_tlb_in,
  input  wire logic        exc_coherency_in,
  input  wire logic        exc_bus_err_in,
  input  wire logic [31:0] exc_vaddr_in,
  input  wire logic        exception_return_instr_in,
  input  wire logic        instr_valid_in,
  // tlb instruction data paths
  input  wire logic        entry_read_in,
  input  wire logic [11:0] entry_mask_in,
  input  wire logic [18:0] entry_page_pair_number_in,
  input  wire logic [7:0]  entry_address_space_id_in,
  output logic      [11:0] entry_mask_out,
  output logic      [3:0]  random_ptr_out,
  // lookup: one entry tag compared against a virtual address
  input  wire logic [31:0] lookup_vaddr_in,
  input  wire logic [18:0] lookup_tag_page_pair_number_in,
  input  wire logic [11:0] lookup_tag_mask_in,
  output logic             lookup_hit_out,
  // segment decode
  output logic             priv_mode_out,
  output logic      [2:0]  seg_kind_out,
  output logic             seg_mapped_out,
  output logic             seg_uncached_out,
  output logic      [2:0]  seg_coherency_out,
  output logic      [31:0] seg_paddr_out,
  output logic      [7:0]  seg_address_space_id_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [8:0]  table_base_field_r;
  logic [18:0] miss_page_pair_number_r;
  logic [11:0] page_mask_r;
  logic [5:0]  bound_r;
  logic [3:0]  random_r;
  logic [31:0] fault_vaddr_r;
  logic [18:0] page_pair_number_r;
  logic [7:0]  address_space_id_r;
  logic        exc_active_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic wr_ptr   = reg_wr_in && (reg_num_in == TLBC_REG_PTR);
  wire logic wr_mask  = reg_wr_in && (reg_num_in == TLBC_REG_MASK);
  wire logic wr_bound = reg_wr_in && (reg_num_in == TLBC_REG_BOUND);
  wire logic wr_ehi   = reg_wr_in && (reg_num_in == TLBC_REG_EHI);

  // fault address loads only outside exception level, miss pointer at any level; bus errors excluded from both
  wire logic fva_event = exc_take_in && !exc_bus_err_in &&
                         (exc_addr_err_in || exc_tlb_in || exc_coherency_in);
  wire logic fva_load  = fva_event && !exception_level_bit_in;
  wire logic tlb_event = exc_take_in && exc_tlb_in && !exc_bus_err_in;

  // lowest value the random pointer may take; a boundary past the table clamps to its top
  wire logic [3:0] rand_floor = (bound_r > 6'(TLBC_RAND_TOP)) ? TLBC_RAND_TOP : bound_r[3:0];
  wire logic [3:0] rand_dec   = (random_r <= rand_floor) ? TLBC_RAND_TOP
                                                          : random_r - 4'h1;

  // tag compare of one entry; the indexed path has no boundary at all
  wire logic [11:0] cmp_diff = lookup_vaddr_in[24:13] ^ lookup_tag_page_pair_number_in[11:0];
  wire logic        hit_nxt  = (lookup_vaddr_in[31:25] == lookup_tag_page_pair_number_in[18:12]) &&
                               ((cmp_diff & ~lookup_tag_mask_in) == 12'h000);

  // ---------------------------------------------------------------
  // mode and segment decode
  // ---------------------------------------------------------------
  // the exception cycle itself is privileged, before the held flag has caught up
  wire logic user_mode = user_mode_bit_in && !exception_level_bit_in &&
                         !error_level_bit_in && !exc_active_r && !exc_take_in;
  wire logic [7:0] va_top = lookup_vaddr_in[31:24];
  tlbc_seg_t seg_nxt;
  assign seg_nxt = user_mode                                      ? TLBC_SEG_USER
                 : !lookup_vaddr_in[31]                           ? TLBC_SEG_USER
                 : (lookup_vaddr_in[31:29] == 3'b100)             ? TLBC_SEG_CACHED
                 : (lookup_vaddr_in[31:29] == 3'b101)             ? TLBC_SEG_UNCACHE
                 : (va_top == TLBC_ONCHIP_TOP && !cfg_map_top_in) ? TLBC_SEG_ONCHIP
                 :                                                  TLBC_SEG_KMAPPED;
  // user mode above 2 Gbytes is an address error for the pipeline; flagged as unmapped here
  wire logic mapped_nxt = (seg_nxt == TLBC_SEG_USER && !lookup_vaddr_in[31]) ||
                          (seg_nxt == TLBC_SEG_KMAPPED);
  wire logic [31:0] paddr_nxt = (seg_nxt == TLBC_SEG_CACHED)  ? lookup_vaddr_in - TLBC_SEG0_BASE
                              : (seg_nxt == TLBC_SEG_UNCACHE) ? lookup_vaddr_in - TLBC_SEG1_BASE
                              :                                 lookup_vaddr_in;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire logic [31:0] rd_nxt =
      (reg_num_in == TLBC_REG_PTR)   ? {table_base_field_r, miss_page_pair_number_r, 4'h0} :
      (reg_num_in == TLBC_REG_MASK)  ? {7'h00, page_mask_r, 13'h0000} :
      (reg_num_in == TLBC_REG_BOUND) ? {26'h0, bound_r} :
      (reg_num_in == TLBC_REG_FVA)   ? fault_vaddr_r :
      (reg_num_in == TLBC_REG_EHI)   ? {page_pair_number_r, 5'h00, address_space_id_r} :
                                       32'h0000_0000;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      table_base_field_r <= '0;
      miss_page_pair_number_r <= '0;
      page_mask_r <= '0;
      page_pair_number_r <= '0;
      address_space_id_r <= '0;
      fault_vaddr_r <= '0;
      exc_active_r <= 1'b0;
    end else begin
      if (wr_ptr)
        table_base_field_r <= reg_wdata_in[31:TLBC_PTR_BASE_LO];
      if (tlb_event)
        miss_page_pair_number_r <= exc_vaddr_in[31:TLBC_PAGE_PAIR_NUMBER_LO];
      // the mask register takes the entry's field when an entry is read
      if (entry_read_in)
        page_mask_r <= entry_mask_in;
      else if (wr_mask)
        page_mask_r <= reg_wdata_in[24:TLBC_MASK_LO];
      if (tlb_event) begin
        page_pair_number_r <= exc_vaddr_in[31:TLBC_PAGE_PAIR_NUMBER_LO];
      end else if (entry_read_in) begin
        page_pair_number_r <= entry_page_pair_number_in;
        address_space_id_r <= entry_address_space_id_in;
      end else if (wr_ehi) begin
        page_pair_number_r <= reg_wdata_in[31:TLBC_PAGE_PAIR_NUMBER_LO];
        address_space_id_r <= reg_wdata_in[7:0];
      end
      if (fva_load)
        fault_vaddr_r <= exc_vaddr_in;
      if (exc_take_in)
        exc_active_r <= 1'b1;
      else if (exception_return_instr_in)
        exc_active_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bound_r  <= TLBC_BOUND_RST;
      random_r <= TLBC_RAND_TOP;
    end else begin
      if (wr_bound) begin
        bound_r  <= reg_wdata_in[TLBC_BOUND_W-1:0];
        random_r <= TLBC_RAND_TOP;
      end else if (instr_valid_in) begin
        random_r <= rand_dec;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out     <= '0;
      entry_mask_out    <= '0;
      random_ptr_out    <= TLBC_RAND_TOP;
      lookup_hit_out    <= 1'b0;
      priv_mode_out     <= 1'b1;
      seg_kind_out      <= TLBC_SEG_USER;
      seg_mapped_out    <= 1'b0;
      seg_uncached_out  <= 1'b0;
      seg_coherency_out <= '0;
      seg_paddr_out     <= '0;
      seg_address_space_id_out      <= '0;
    end else begin
      reg_rdata_out     <= rd_nxt;
      entry_mask_out    <= page_mask_r;
      random_ptr_out    <= random_r;
      lookup_hit_out    <= hit_nxt;
      priv_mode_out     <= !user_mode;
      seg_kind_out      <= seg_nxt;
      seg_mapped_out    <= mapped_nxt;
      seg_uncached_out  <= (seg_nxt == TLBC_SEG_UNCACHE) || (seg_nxt == TLBC_SEG_ONCHIP);
      seg_coherency_out <= segment_coherency_field_in;
      seg_paddr_out     <= paddr_nxt;
      seg_address_space_id_out      <= address_space_id_r;
    end
  end

endmodule

// ### tb/tlbc_pipe_model.sv
// pipeline stand-in: issues a burst of valid-instruction pulses on request
// assumes go_in is a one-cycle pulse and the previous burst has finished
`timescale 1ns/10ps
module tlbc_pipe_model (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       go_in,
  input  wire logic [4:0] burst_in,
  output logic            instr_valid_out
);
  logic [4:0] left_r;
  assign instr_valid_out = (left_r != 5'h00);
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) left_r <= 5'h00;
    else if (go_in) left_r <= burst_in;
    else if (left_r != 5'h00) left_r <= left_r - 5'h01;
  end
endmodule

// ### tb/tlbc_top_chk.sv
// checker for tlbc_top port relations
// assumes one clock domain and the one-cycle output latency of the design
// the random pointer output trails its register, so pointer checks look two edges ahead
`timescale 1ns/10ps
module tlbc_top_chk
  import tlbc_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        reg_wr_in,
  input  wire logic        instr_valid_in,
  input  wire logic        exc_take_in,
  input  wire logic        user_mode_bit_in,
  input  wire logic        exception_level_bit_in,
  input  wire logic        error_level_bit_in,
  input  wire logic        cfg_map_top_in,
  input  wire logic [4:0]  reg_num_in,
  input  wire logic [2:0]  segment_coherency_field_in,
  input  wire logic [2:0]  seg_kind_out,
  input  wire logic [2:0]  seg_coherency_out,
  input  wire logic [31:0] lookup_vaddr_in,
  input  wire logic [31:0] seg_paddr_out,
  input  wire logic [18:0] lookup_tag_page_pair_number_in,
  input  wire logic [11:0] lookup_tag_mask_in,
  input  wire logic [3:0]  random_ptr_out,
  input  wire logic        lookup_hit_out,
  input  wire logic        priv_mode_out,
  input  wire logic        seg_mapped_out,
  input  wire logic        seg_uncached_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // masked tag difference; a set mask bit drops that address bit
  wire logic [18:0] diff = (lookup_vaddr_in[31:13] ^ lookup_tag_page_pair_number_in) & ~{7'h00, lookup_tag_mask_in};
  wire logic        wr_bnd = reg_wr_in && reg_num_in == TLBC_REG_BOUND;
  wire logic        kern = !user_mode_bit_in;
  property p_bnd_wr;
    wr_bnd |=> ##1 random_ptr_out == TLBC_RAND_TOP;
  endproperty
  a_bnd_wr: assert property (p_bnd_wr) else $error("random not at top after bound write");
  property p_rnd_hold;
    !instr_valid_in && !wr_bnd |=> ##1 $stable(random_ptr_out);
  endproperty
  a_rnd_hold: assert property (p_rnd_hold) else $error("random moved without instruction");
  property p_rnd_dec;
    instr_valid_in && !wr_bnd |=> ##1 (random_ptr_out == $past(random_ptr_out) - 4'h1) ||
                                      (random_ptr_out == TLBC_RAND_TOP);
  endproperty
  a_rnd_dec: assert property (p_rnd_dec) else $error("random step wrong");
  property p_priv; !user_mode_bit_in || exception_level_bit_in || error_level_bit_in |=> priv_mode_out; endproperty
  a_priv: assert property (p_priv) else $error("privileged mode missing");
  property p_exc; exc_take_in |=> priv_mode_out [*2]; endproperty
  a_exc: assert property (p_exc) else $error("exception did not enter privileged mode");
  property p_seg0;
    kern && lookup_vaddr_in[31:29] == 3'b100 |=>
      seg_kind_out == TLBC_SEG_CACHED && !seg_mapped_out &&
      seg_paddr_out == $past(lookup_vaddr_in) - TLBC_SEG0_BASE &&
      seg_coherency_out == $past(segment_coherency_field_in);
  endproperty
  a_seg0: assert property (p_seg0) else $error("cached segment decode wrong");
  property p_seg1;
    kern && lookup_vaddr_in[31:29] == 3'b101 |=>
      seg_uncached_out && !seg_mapped_out &&
      seg_paddr_out == $past(lookup_vaddr_in) - TLBC_SEG1_BASE;
  endproperty
  a_seg1: assert property (p_seg1) else $error("uncached segment decode wrong");
  property p_useg; kern && !lookup_vaddr_in[31] |=> seg_mapped_out && seg_kind_out == 3'h0; endproperty
  a_useg: assert property (p_useg) else $error("user segment decode wrong");
  property p_top; kern && lookup_vaddr_in[31:24] == 8'hff |=> seg_mapped_out == $past(cfg_map_top_in); endproperty
  a_top: assert property (p_top) else $error("top region mapping wrong");
  property p_hit; 1'b1 |=> lookup_hit_out == ($past(diff) == 19'h0); endproperty
  a_hit: assert property (p_hit) else $error("lookup hit wrong");
endmodule
bind tlbc_top tlbc_top_chk u_chk (.*);

// ### tb/testbench.sv
// self-checking bench for tlbc_top with a pipeline stand-in
// assumes the registered read and one-cycle output timing of the design
`timescale 1ns/10ps
module testbench;
  import tlbc_pkg::*;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, user_mode_bit_in = 1'b0, exception_level_bit_in = 1'b0;
  logic error_level_bit_in = 1'b0, cfg_map_top_in = 1'b0, exc_take_in = 1'b0, exc_addr_err_in = 1'b0;
  logic exc_tlb_in = 1'b0, exc_coherency_in = 1'b0, exc_bus_err_in = 1'b0, exception_return_instr_in = 1'b0;
  logic entry_read_in = 1'b0, go = 1'b0;
  logic instr_valid_in, lookup_hit_out, priv_mode_out, seg_mapped_out, seg_uncached_out;
  logic [2:0]  segment_coherency_field_in = 3'h3, seg_kind_out, seg_coherency_out;
  logic [3:0]  random_ptr_out;
  logic [4:0]  reg_num_in = 5'h00, burst = 5'h00;
  logic [7:0]  entry_address_space_id_in = 8'h00, seg_address_space_id_out;
  logic [11:0] entry_mask_in = 12'h000, entry_mask_out, lookup_tag_mask_in = 12'h000;
  logic [18:0] entry_page_pair_number_in = 19'h0, lookup_tag_page_pair_number_in = 19'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, exc_vaddr_in = 32'h0, lookup_vaddr_in = 32'h0, seg_paddr_out;
  int error_cnt = 0, total_checks = 0;
  tlbc_top u_dut (.*);
  tlbc_pipe_model u_pipe (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .go_in(go), .burst_in(burst),
                          .instr_valid_out(instr_valid_in));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic cyc(int n = 1); repeat (n) @(posedge mclk_in); #1; endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // an idle edge follows each write, so back-to-back writes never re-raise the strobe in one time step
  task automatic wr(logic [4:0] n, logic [31:0] d);
    reg_num_in   = n;
    reg_wdata_in = d;
    reg_wr_in    = 1'b1;
    cyc();
    reg_wr_in    = 1'b0;
    cyc();
  endtask
  task automatic rd(logic [4:0] n, logic [31:0] e); reg_num_in = n; cyc(); chk(reg_rdata_out, e); endtask
  task automatic exc(logic [31:0] va, logic t, logic a, logic b);
    exc_vaddr_in = va; exc_tlb_in = t; exc_addr_err_in = a; exc_bus_err_in = b; exc_take_in = 1'b1;
    cyc();
    exc_take_in = 1'b0;
  endtask
  // one edge past the burst, since the pointer output trails its register
  task automatic run(logic [4:0] n);
    burst = n;
    go    = 1'b1;
    cyc();
    go    = 1'b0;
    cyc(int'(n) + 1);
  endtask
  task automatic t_random;
    rd(TLBC_REG_BOUND, 32'h0);
    chk(32'(random_ptr_out), 32'hf);
    run(5'd2);
    chk(32'(random_ptr_out), 32'hd);
    wr(TLBC_REG_BOUND, 32'h3);
    chk(32'(random_ptr_out), 32'hf);
    run(5'd12);
    chk(32'(random_ptr_out), 32'h3);
    run(5'd1);
    chk(32'(random_ptr_out), 32'hf);
    $display("test random done");
  endtask
  task automatic t_fault;
    user_mode_bit_in = 1'b1;
    wr(TLBC_REG_PTR, 32'hff80_0000);
    wr(TLBC_REG_EHI, 32'hffff_ff5a);
    rd(TLBC_REG_EHI, 32'hffff_e05a);
    exc(32'h1234_5678, 1'b1, 1'b0, 1'b0);
    rd(TLBC_REG_FVA, 32'h1234_5678);
    rd(TLBC_REG_EHI, 32'h1234_405a);
    rd(TLBC_REG_PTR, 32'hff89_1a20);
    exception_level_bit_in = 1'b1;
    exc(32'hdead_0000, 1'b0, 1'b1, 1'b0);
    exception_level_bit_in = 1'b0;
    rd(TLBC_REG_FVA, 32'h1234_5678);
    exc(32'h0bad_0000, 1'b0, 1'b1, 1'b1);
    rd(TLBC_REG_FVA, 32'h1234_5678);
    exc(32'h0000_4000, 1'b0, 1'b1, 1'b0);
    rd(TLBC_REG_FVA, 32'h0000_4000);
    exc_coherency_in = 1'b1;
    exc(32'h0000_8000, 1'b0, 1'b0, 1'b0);
    exc_coherency_in = 1'b0;
    rd(TLBC_REG_FVA, 32'h0000_8000);
    user_mode_bit_in = 1'b0;
    $display("test fault done");
  endtask
  task automatic t_mask;
    wr(TLBC_REG_MASK, 32'h0007_e000);
    cyc();
    chk(32'(entry_mask_out), 32'h03f);
    entry_mask_in = 12'h0ff;
    entry_page_pair_number_in = 19'h00abc;
    entry_address_space_id_in = 8'h3c;
    entry_read_in = 1'b1;
    cyc();
    entry_read_in = 1'b0;
    rd(TLBC_REG_MASK, 32'h001f_e000);
    chk(32'(seg_address_space_id_out), 32'h3c);
    rd(TLBC_REG_EHI, 32'h0157_803c);
    $display("test mask done");
  endtask
  task automatic t_seg;
    logic [31:0] va [6] = '{32'h0000_1000, 32'h8000_1000, 32'ha000_2000, 32'hc000_0000, 32'hff00_0000, 32'hff00_0000};
    logic [2:0]  kd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3};
    for (int i = 0; i < 6; i++) begin
      lookup_vaddr_in = va[i]; cfg_map_top_in = (i == 5); cyc();
      chk(32'(seg_kind_out), 32'(kd[i]));
      chk(32'(seg_mapped_out), 32'(kd[i] == 3'h0 || kd[i] == 3'h3));
      if (i == 1 || i == 2) chk(seg_paddr_out, va[i] - (i == 1 ? TLBC_SEG0_BASE : TLBC_SEG1_BASE));
      if (i != 4) chk(32'(seg_uncached_out), 32'(kd[i] == 3'h2));
    end
    user_mode_bit_in = 1'b1; lookup_vaddr_in = 32'h0000_1000; cyc();
    chk(32'(priv_mode_out), 32'h1);
    exception_return_instr_in = 1'b1; cyc(); exception_return_instr_in = 1'b0; cyc();
    chk(32'(priv_mode_out), 32'h0);
    chk(32'(seg_mapped_out), 32'h1);
    exception_level_bit_in = 1'b1; cyc(); exception_level_bit_in = 1'b0;
    chk(32'(priv_mode_out), 32'h1);
    user_mode_bit_in = 1'b0;
    // address bit 16 differs from the tag: only the 64 Kbyte mask drops it
    lookup_vaddr_in = 32'h0001_0000;
    for (int i = 0; i < 3; i++) begin
      lookup_tag_mask_in = (i == 0) ? 12'h000 : (i == 1) ? 12'h003 : 12'h00f;
      cyc();
      chk(32'(lookup_hit_out), 32'(i == 2));
    end
    $display("test segment done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    t_random();
    t_fault();
    t_mask();
    t_seg();
    finish_test();
  end
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule
